// ---- hw/socc_pkg.sv ----
// Package with register map, reset values and timing constants of the sensor control block.
package socc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_HOLD = 15'h3001;
  localparam logic [14:0] ADDR_SWRST = 15'h3003;
  localparam logic [14:0] ADDR_CONV = 15'h3005;
  localparam logic [14:0] ADDR_WIN = 15'h3007;
  localparam logic [14:0] ADDR_FRATE = 15'h3009;
  localparam logic [14:0] ADDR_OUTFMT = 15'h3046;
  localparam logic [14:0] ADDR_CK1 = 15'h305C;
  localparam logic [14:0] ADDR_CK2 = 15'h305D;
  localparam logic [14:0] ADDR_CK3 = 15'h305E;
  localparam logic [14:0] ADDR_CK4 = 15'h305F;
  localparam logic [14:0] ADDR_AUX1 = 15'h3129;
  localparam logic [14:0] ADDR_CK5 = 15'h315E;
  localparam logic [14:0] ADDR_CK6 = 15'h3164;
  localparam logic [14:0] ADDR_AUX2 = 15'h317C;
  localparam logic [14:0] ADDR_AUX3 = 15'h31EC;
  localparam logic [14:0] ADDR_CK7 = 15'h3480;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WIN_LSB = 4;
  localparam int FMT_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_HOLD = 1'h0;
  localparam logic RST_CONV = 1'h1;
  localparam logic [2:0] RST_WIN = 3'h0;
  localparam logic [1:0] RST_FRATE = 2'h1;
  localparam logic RST_OWIDTH = 1'h1;
  localparam logic [3:0] RST_FMT = 4'hE;
  localparam logic [7:0] RST_CK [0:6] = '{8'h0C, 8'h00, 8'h10, 8'h01, 8'h1B, 8'h1B, 8'h92};
  localparam logic [7:0] RST_AUX [0:2] = '{8'h1D, 8'h12, 8'h37};

  // ----------------------------------------------------------------
  // Field encodings and pixel limits
  // ----------------------------------------------------------------
  localparam logic [2:0] WIN_FULL = 3'h0;
  localparam logic [2:0] WIN_720 = 3'h1;
  localparam logic [2:0] WIN_CROP = 3'h4;
  localparam logic [3:0] FMT_LVDS2 = 4'hD;
  localparam logic [3:0] FMT_LVDS4 = 4'hE;
  localparam logic [11:0] PIX_MIN_LVDS = 12'h001;
  localparam logic [11:0] PIX_MAX10_LVDS = 12'h3FE;
  localparam logic [11:0] PIX_MAX12_LVDS = 12'hFFE;
  localparam logic [3:0] BITS10 = 4'hA;
  localparam logic [3:0] BITS12 = 4'hC;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SWRST_DELAY_NS = 500;
  localparam int SWRST_CYCLES_INT = (SWRST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] SWRST_CYCLES = SWRST_CYCLES_INT[4:0];
  localparam logic [4:0] SERIAL_LAST_BIT = 5'h17;
  localparam logic [4:0] SERIAL_ADDR_BITS = 5'h10;

endpackage

// ---- hw/socc_serial_slave.sv ----
// Serial register port: frames of a 16-bit address word then one data byte, MSB first.
`timescale 1ns/10ps
module socc_serial_slave
  import socc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Serial pins.
  input wire logic chip_enable_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Register side.
  output logic reg_write,
  output logic reg_read,
  output logic [14:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ce_sync; // Chip enable, two stages.
  logic [1:0] sck_sync; // Serial clock, two stages.
  logic [1:0] sdi_sync; // Serial data, two stages.
  logic sck_last; // Previous synchronised serial clock.
  logic [4:0] bit_count; // Bits taken in this frame.
  logic [23:0] shift_in; // Incoming bits.
  logic [7:0] shift_out; // Read data being sent.
  logic read_frame; // Set when the address word asks for a read.

  // Each pin passes two flops before any logic sees it.
  always_ff @(posedge clock) begin
    ce_sync <= {ce_sync[0], chip_enable_n};
    sck_sync <= {sck_sync[0], serial_clock};
    sdi_sync <= {sdi_sync[0], serial_data_in};
    sck_last <= sck_sync[1];
  end

  // Rising edges of the serial clock take in bits; a deselect restarts the frame.
  always_ff @(posedge clock) begin
    if (!nrst || ce_sync[1]) begin
      bit_count <= 5'h00;
      shift_in <= 24'h000000;
      read_frame <= 1'b0;
    end else if (sck_sync[1] && !sck_last && bit_count <= SERIAL_LAST_BIT) begin
      shift_in <= {shift_in[22:0], sdi_sync[1]};
      bit_count <= bit_count + 5'h01;
      if (bit_count == SERIAL_ADDR_BITS - 5'h01) begin
        read_frame <= shift_in[14];
      end
    end
  end

  // Address is latched after sixteen bits and the strobes fire once per frame.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_addr <= 15'h0000;
      reg_wdata <= 8'h00;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
    end else begin
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      if (sck_sync[1] && !sck_last && !ce_sync[1]) begin
        if (bit_count == SERIAL_ADDR_BITS - 5'h01) begin
          reg_addr <= {shift_in[13:0], sdi_sync[1]};
          reg_read <= shift_in[14];
        end else if (bit_count == SERIAL_LAST_BIT && !read_frame) begin
          reg_wdata <= {shift_in[6:0], sdi_sync[1]};
          reg_write <= 1'b1;
        end
      end
    end
  end

  // Read data is loaded after the address and advanced on falling edges.
  always_ff @(posedge clock) begin
    if (!nrst || ce_sync[1]) begin
      shift_out <= 8'h00;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else if (reg_read) begin
      shift_out <= {reg_rdata[6:0], 1'b0};
      serial_data_out <= reg_rdata[7];
      serial_data_oe <= 1'b1;
    end else if (!sck_sync[1] && sck_last && read_frame && bit_count > SERIAL_ADDR_BITS) begin
      serial_data_out <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

endmodule

// ---- hw/socc_word_serializer.sv ----
// Differential serial output shifter: sends one 10 or 12 bit word MSB first.
`timescale 1ns/10ps
module socc_word_serializer
  import socc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Word side.
  input wire logic word_valid,
  input wire logic [11:0] word,
  input wire logic wide_word,
  input wire logic line_enable,
  output logic word_ready,
  // Line side.
  output logic line_data,
  output logic line_oe
);

  logic [11:0] shift; // Rest of the word left-aligned, next bit to send in bit 11.
  logic [3:0] remaining; // Bits still to send.

  // A new word is accepted only when the previous one has gone out.
  always_comb begin
    word_ready = (remaining == 4'h0);
  end

  // Loads left-aligned so the most significant bit always leaves first.
  always_ff @(posedge clock) begin
    if (!nrst || !line_enable) begin
      shift <= 12'h000;
      remaining <= 4'h0;
      line_data <= 1'b0;
    end else if (word_valid && word_ready) begin
      shift <= wide_word ? {word[10:0], 1'b0} : {word[8:0], 3'h0};
      line_data <= wide_word ? word[11] : word[9];
      remaining <= wide_word ? BITS12 - 4'h1 : BITS10 - 4'h1;
    end else if (remaining != 4'h0) begin
      line_data <= shift[11];
      shift <= {shift[10:0], 1'b0};
      remaining <= remaining - 4'h1;
    end
  end

  // The line floats whenever the output is disabled.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      line_oe <= 1'b0;
    end else begin
      line_oe <= line_enable;
    end
  end

endmodule

// ---- hw/socc_core.sv ----
// Sensor output configuration and control: registers, hold, soft reset, pixel output.
`timescale 1ns/10ps
module socc_core
  import socc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Serial register port.
  input wire logic chip_enable_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Mode pins and frame timing.
  input wire logic master_mode_pin,
  input wire logic csi_mode_pin,
  input wire logic reflect_point,
  input wire logic standby_release,
  input wire logic frame_sync_gen,
  input wire logic line_sync_gen,
  // Pixel input from the converter.
  input wire logic pixel_valid,
  input wire logic [11:0] pixel_in,
  input wire logic pixel_is_sync,
  output logic pixel_ready,
  // Pixel and serial outputs.
  output logic pixel_out_valid,
  output logic [11:0] pixel_out,
  output logic serial_line_data,
  output logic serial_line_oe,
  output logic frame_sync_out,
  output logic line_sync_out,
  // Active configuration.
  output logic standby,
  output logic frame_invalid,
  output logic conv_width_12,
  output logic [7:0] conv_aux [0:2],
  output logic [7:0] clock_setting [0:6],
  output logic [1:0] frame_rate,
  output logic readout_full,
  output logic readout_720,
  output logic readout_crop,
  output logic lvds_four_channel
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] master_sync; // Master mode pin synchroniser.
  logic [1:0] csi_sync; // Output mode pin synchroniser.
  logic reg_write; // One-cycle write strobe from the serial port.
  logic reg_read; // One-cycle read strobe from the serial port.
  logic [14:0] reg_addr; // Register address of the frame.
  logic [7:0] reg_wdata; // Write data of the frame.
  logic [7:0] reg_rdata; // Read data back to the serial port.
  logic register_hold_control; // Hold bit, acts at once.
  logic soft_reset_trigger; // Soft reset request bit.
  logic [4:0] swrst_count; // Cycles since the soft reset write.
  logic swrst_apply; // One-cycle pulse that restores defaults.
  logic conversion_width_select; // Shadow conversion width.
  logic [2:0] window_mode_select; // Shadow window mode.
  logic [1:0] frame_rate_select; // Shadow frame rate.
  logic output_width_select; // Shadow output width.
  logic [3:0] output_format_select; // Shadow output format.
  logic [7:0] clock_shadow [0:6]; // Shadow clock settings.
  logic [7:0] aux_shadow [0:2]; // Shadow conversion aux settings.
  logic out_wide; // Active output width.
  logic [3:0] out_format; // Active output format.
  logic [2:0] win_active; // Active window mode.
  logic [11:0] next_pixel; // Clamped and sized pixel word.
  logic ser_ready; // Serializer can take a word.

  // Index of a clock setting register, 7 when the address is not one.
  function automatic logic [2:0] clock_index(input logic [14:0] addr);
    case (addr)
      ADDR_CK1: clock_index = 3'h0;
      ADDR_CK2: clock_index = 3'h1;
      ADDR_CK3: clock_index = 3'h2;
      ADDR_CK4: clock_index = 3'h3;
      ADDR_CK5: clock_index = 3'h4;
      ADDR_CK6: clock_index = 3'h5;
      ADDR_CK7: clock_index = 3'h6;
      default: clock_index = 3'h7;
    endcase
  endfunction

  // Index of a conversion aux register, 3 when the address is not one.
  function automatic logic [1:0] aux_index(input logic [14:0] addr);
    case (addr)
      ADDR_AUX1: aux_index = 2'h0;
      ADDR_AUX2: aux_index = 2'h1;
      ADDR_AUX3: aux_index = 2'h2;
      default: aux_index = 2'h3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  socc_serial_slave u_serial (
    .clock(clock),
    .nrst(nrst),
    .chip_enable_n(chip_enable_n),
    .serial_clock(serial_clock),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // Mode pins pass two flops before use.
  always_ff @(posedge clock) begin
    master_sync <= {master_sync[0], master_mode_pin};
    csi_sync <= {csi_sync[0], csi_mode_pin};
  end

  // ----------------------------------------------------------------
  // Soft reset sequencing
  // ----------------------------------------------------------------
  // The request bit stays set while the delay runs, then clears itself.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      soft_reset_trigger <= 1'b0;
      swrst_count <= 5'h00;
      swrst_apply <= 1'b0;
    end else begin
      swrst_apply <= 1'b0;
      if (soft_reset_trigger) begin
        if (swrst_count == SWRST_CYCLES - 5'h01) begin
          soft_reset_trigger <= 1'b0;
          swrst_count <= 5'h00;
          swrst_apply <= 1'b1;
        end else begin
          swrst_count <= swrst_count + 5'h01;
        end
      end else if (reg_write && reg_addr == ADDR_SWRST && reg_wdata[0]) begin
        soft_reset_trigger <= 1'b1;
      end
    end
  end

  // Standby is entered by the soft reset and left on a release pulse.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      standby <= 1'b0;
    end else if (swrst_apply) begin
      standby <= 1'b1;
    end else if (standby_release) begin
      standby <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  // Writes land in the shadows at once; any value is kept, even a prohibited one.
  always_ff @(posedge clock) begin
    if (!nrst || swrst_apply) begin
      register_hold_control <= RST_HOLD;
      conversion_width_select <= RST_CONV;
      window_mode_select <= RST_WIN;
      frame_rate_select <= RST_FRATE;
      output_width_select <= RST_OWIDTH;
      output_format_select <= RST_FMT;
      clock_shadow <= RST_CK;
      aux_shadow <= RST_AUX;
    end else if (reg_write) begin
      case (reg_addr)
        ADDR_HOLD: register_hold_control <= reg_wdata[0];
        ADDR_CONV: conversion_width_select <= reg_wdata[0];
        ADDR_WIN: window_mode_select <= reg_wdata[WIN_LSB +: 3];
        ADDR_FRATE: frame_rate_select <= reg_wdata[1:0];
        ADDR_OUTFMT: begin
          output_width_select <= reg_wdata[0];
          output_format_select <= reg_wdata[FMT_LSB +: 4];
        end
        default: begin
          if (clock_index(reg_addr) != 3'h7) begin
            clock_shadow[clock_index(reg_addr)] <= reg_wdata;
          end
          if (aux_index(reg_addr) != 2'h3) begin
            aux_shadow[aux_index(reg_addr)] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // Read data shows the shadows and the live soft reset bit; unmapped reads zero.
  always_comb begin
    reg_rdata = 8'h00;
    case (reg_addr)
      ADDR_HOLD: reg_rdata = {7'h00, register_hold_control};
      ADDR_SWRST: reg_rdata = {7'h00, soft_reset_trigger};
      ADDR_CONV: reg_rdata = {7'h00, conversion_width_select};
      ADDR_WIN: reg_rdata = {1'b0, window_mode_select, 4'h0};
      ADDR_FRATE: reg_rdata = {6'h00, frame_rate_select};
      ADDR_OUTFMT: reg_rdata = {output_format_select, 3'h0, output_width_select};
      default: begin
        if (clock_index(reg_addr) != 3'h7) begin
          reg_rdata = clock_shadow[clock_index(reg_addr)];
        end else if (aux_index(reg_addr) != 2'h3) begin
          reg_rdata = aux_shadow[aux_index(reg_addr)];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Reflection to active settings
  // ----------------------------------------------------------------
  // Shadows move together at a reflection point only while hold is clear.
  always_ff @(posedge clock) begin
    if (!nrst || swrst_apply) begin
      conv_width_12 <= RST_CONV;
      conv_aux <= RST_AUX;
      clock_setting <= RST_CK;
      frame_rate <= RST_FRATE;
      out_wide <= RST_OWIDTH;
      out_format <= RST_FMT;
      win_active <= RST_WIN;
    end else if (reflect_point && !register_hold_control) begin
      conv_width_12 <= conversion_width_select;
      conv_aux <= aux_shadow;
      clock_setting <= clock_shadow;
      frame_rate <= frame_rate_select;
      out_wide <= output_width_select;
      out_format <= output_format_select;
      win_active <= window_mode_select;
    end
  end

  // Decoded readout and lane modes.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      readout_full <= 1'b1;
      readout_720 <= 1'b0;
      readout_crop <= 1'b0;
      lvds_four_channel <= 1'b1;
    end else begin
      readout_full <= (win_active == WIN_FULL);
      readout_720 <= (win_active == WIN_720);
      readout_crop <= (win_active == WIN_CROP);
      lvds_four_channel <= (out_format == FMT_LVDS4);
    end
  end

  // A window mode change taken without standby marks the following frame invalid.
  always_ff @(posedge clock) begin
    if (!nrst || swrst_apply) begin
      frame_invalid <= 1'b0;
    end else if (reflect_point && !register_hold_control) begin
      frame_invalid <= (win_active != window_mode_select) && !standby;
    end
  end

  // ----------------------------------------------------------------
  // Pixel output path
  // ----------------------------------------------------------------
  // Sizes the word to the active width and clamps serial pixels off the sync codes.
  always_comb begin
    next_pixel = out_wide ? pixel_in : {2'h0, pixel_in[11:2]};
    if (!csi_sync[1] && !pixel_is_sync) begin
      if (next_pixel < PIX_MIN_LVDS) begin
        next_pixel = PIX_MIN_LVDS;
      end else if (out_wide && next_pixel > PIX_MAX12_LVDS) begin
        next_pixel = PIX_MAX12_LVDS;
      end else if (!out_wide && next_pixel > PIX_MAX10_LVDS) begin
        next_pixel = PIX_MAX10_LVDS;
      end
    end
  end

  // Registers the output word; CSI words pass at full range.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pixel_out <= 12'h000;
      pixel_out_valid <= 1'b0;
    end else begin
      pixel_out <= next_pixel;
      pixel_out_valid <= pixel_valid && pixel_ready && !standby && (csi_sync[1] || ser_ready);
    end
  end

  // Stalls the source in standby and, in serial mode, while a word is in flight or the serializer is busy.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pixel_ready <= 1'b0;
    end else begin
      pixel_ready <= !standby && !swrst_apply && (csi_sync[1] || (ser_ready && !pixel_out_valid
        && !(pixel_valid && pixel_ready)));
    end
  end

  // Serial line shifter, floated in standby and in CSI mode.
  socc_word_serializer u_ser (
    .clock(clock),
    .nrst(nrst),
    .word_valid(pixel_out_valid && !csi_sync[1]),
    .word(pixel_out),
    .wide_word(out_wide),
    .line_enable(!standby && !swrst_apply && !csi_sync[1]),
    .word_ready(ser_ready),
    .line_data(serial_line_data),
    .line_oe(serial_line_oe)
  );

  // Sync outputs sit high in master mode standby, else follow the generator.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      frame_sync_out <= 1'b1;
      line_sync_out <= 1'b1;
    end else if ((standby || swrst_apply) && master_sync[1]) begin
      frame_sync_out <= 1'b1;
      line_sync_out <= 1'b1;
    end else begin
      frame_sync_out <= frame_sync_gen;
      line_sync_out <= line_sync_gen;
    end
  end

endmodule

// ---- tb/socc_monitor.sv ----
// Checker of the sensor control block's port behaviour.
`timescale 1ns/10ps
module socc_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Watched ports.
  input wire logic chip_enable_n,
  input wire logic serial_data_oe,
  input wire logic reflect_point,
  input wire logic standby_release,
  input wire logic pixel_valid,
  input wire logic csi_mode_pin,
  input wire logic pixel_ready,
  input wire logic pixel_out_valid,
  input wire logic [11:0] pixel_out,
  input wire logic serial_line_oe,
  input wire logic frame_sync_out,
  input wire logic line_sync_out,
  input wire logic standby,
  input wire logic frame_invalid,
  input wire logic [1:0] frame_rate,
  input wire logic readout_full,
  input wire logic readout_720,
  input wire logic readout_crop
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Steps: a word accepted, and the entry into standby.
  sequence word_taken; pixel_valid && pixel_ready; endsequence
  sequence enter_standby; $rose(standby); endsequence
  pixel_answer_a: assert property (word_taken |=> pixel_out_valid)
    else $error("pixel not answered");
  pixel_clamp_a: assert property (pixel_out_valid && !csi_mode_pin |->
    pixel_out >= 12'h001 && pixel_out <= 12'hFFE)
    else $error("pixel outside range");
  sync_high_a: assert property (enter_standby |-> frame_sync_out && line_sync_out)
    else $error("syncs not high");
  line_float_a: assert property (standby |-> !serial_line_oe)
    else $error("line driven in standby");
  window_onehot_a: assert property ($onehot0({readout_full, readout_720, readout_crop}))
    else $error("readout decode clash");
  active_stable_a: assert property (!$past(reflect_point) && !$rose(standby) |-> $stable(frame_rate))
    else $error("setting moved");
  standby_exit_a: assert property (standby && standby_release |=> !standby)
    else $error("standby kept");
  invalid_cause_a: assert property ($rose(frame_invalid) |-> $past(reflect_point) || $past(reflect_point, 2))
    else $error("invalid frame uncaused");
  read_release_a: assert property (chip_enable_n [*4] |-> !serial_data_oe)
    else $error("read data held");
endmodule
bind socc_core socc_monitor mon_u (.clock, .nrst, .chip_enable_n, .serial_data_oe, .reflect_point,
  .standby_release, .pixel_valid, .csi_mode_pin, .pixel_ready, .pixel_out_valid, .pixel_out,
  .serial_line_oe,
  .frame_sync_out, .line_sync_out, .standby, .frame_invalid, .frame_rate, .readout_full,
  .readout_720, .readout_crop);

// ---- tb/socc_host_model.sv ----
// Host controller model driving the serial register port.
`timescale 1ns/10ps
module socc_host_model (
  // Clock.
  input wire logic clock,
  // Serial pins.
  output logic chip_enable_n,
  output logic serial_clock,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  // Chip enable stays high through clear and the wait after it.
  initial begin
    chip_enable_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // One access a frame: flag, address, data, MSB first, slow phases.
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      output logic [7:0] rdv);
    logic [23:0] f;
    f = {rd, a, wd};
    chip_enable_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(posedge clock);
      serial_data_in <= f[i];
      repeat (4) @(posedge clock);
      serial_clock <= 1'b1;
      repeat (4) @(posedge clock);
      rdv[i % 8] = serial_data_oe ? serial_data_out : 1'bx;
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge clock);
    chip_enable_n <= 1'b1;
    serial_data_in <= ~f[0];
    repeat (6) @(posedge clock);
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the sensor control block.
`timescale 1ns/10ps
module tb;
  import socc_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic reflect_point = 1'b0;
  logic standby_release = 1'b0;
  logic pixel_valid = 1'b0;
  logic [11:0] pixel_in = 12'h000;
  logic chip_enable_n, serial_clock, serial_data_in, serial_data_out, serial_data_oe;
  logic pixel_ready, pixel_out_valid, serial_line_data, serial_line_oe, frame_sync_out;
  logic line_sync_out, standby, frame_invalid, readout_full, readout_720, readout_crop, lvds4;
  logic conv12;
  logic [11:0] pixel_out;
  logic [1:0] frame_rate;
  logic [7:0] conv_aux [0:2];
  logic [7:0] clock_setting [0:6];
  logic [7:0] rv;
  int num_errors = 0;
  int check_count = 0;
  // Free-running clock, stable before clear is released.
  always #20 clock = ~clock;
  socc_host_model host_u (.clock, .chip_enable_n, .serial_clock, .serial_data_in,
    .serial_data_out, .serial_data_oe);
  // Master mode, serial output (never CSI), no sync words.
  socc_core dut_u (.clock, .nrst, .chip_enable_n, .serial_clock, .serial_data_in,
    .serial_data_out, .serial_data_oe, .master_mode_pin(1'b1), .csi_mode_pin(1'b0),
    .reflect_point, .standby_release, .frame_sync_gen(1'b0), .line_sync_gen(1'b0),
    .pixel_valid, .pixel_in, .pixel_is_sync(1'b0), .pixel_ready, .pixel_out_valid, .pixel_out,
    .serial_line_data, .serial_line_oe, .frame_sync_out, .line_sync_out, .standby,
    .frame_invalid, .conv_width_12(conv12), .conv_aux, .clock_setting, .frame_rate, .readout_full,
    .readout_720, .readout_crop, .lvds_four_channel(lvds4));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, rv);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    host_u.xfer(1'b1, a, 8'h00, rv);
    chk({4'h0, rv}, {4'h0, e});
  endtask
  task automatic reflect();
    reflect_point <= 1'b1;
    @(posedge clock);
    reflect_point <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // Defaults after clear; clock settings suit the faster master clock.
  task automatic t_defaults();
    rd(ADDR_CONV, {7'h00, RST_CONV});
    rd(ADDR_OUTFMT, {RST_FMT, 3'h0, RST_OWIDTH});
    rd(ADDR_CK7, RST_CK[6]);
    rd(15'h3002, 8'h00);
    chk({10'h000, frame_rate}, {10'h000, RST_FRATE});
    chk({4'h0, clock_setting[6]}, {4'h0, RST_CK[6]});
    chk({11'h000, conv12}, {11'h000, RST_CONV});
  endtask
  // Shadow writes wait for reflection; hold keeps them pending.
  task automatic t_hold();
    wr(ADDR_FRATE, 8'h02);
    chk({10'h000, frame_rate}, 12'h001);
    reflect();
    chk({10'h000, frame_rate}, 12'h002);
    wr(ADDR_HOLD, 8'h01);
    wr(ADDR_FRATE, 8'h01);
    wr(ADDR_AUX1, 8'h00);
    wr(ADDR_AUX2, 8'h00);
    wr(ADDR_AUX3, 8'h0E);
    reflect();
    chk({10'h000, frame_rate}, 12'h002);
    chk({4'h0, conv_aux[2]}, 12'h037);
    wr(ADDR_HOLD, 8'h00);
    reflect();
    chk({conv_aux[0], conv_aux[2][3:0]}, 12'h00E);
    chk({10'h000, frame_rate}, 12'h001);
  endtask
  // Every window mode, each change flagging an invalid frame.
  task automatic t_window();
    logic [2:0] m [0:2];
    m = '{WIN_720, WIN_CROP, WIN_FULL};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_WIN, {1'b0, m[i], 4'h0});
      reflect();
      chk({9'h000, readout_crop, readout_720, readout_full},
        {9'h000, m[i] == WIN_CROP, m[i] == WIN_720, m[i] == WIN_FULL});
      chk({11'h000, frame_invalid}, 12'h001);
    end
  endtask
  // Soft reset: bit self-clears, defaults back, standby with floating line.
  task automatic t_softreset();
    wr(ADDR_SWRST, 8'h01);
    rd(ADDR_SWRST, 8'h00);
    chk({8'h00, standby, frame_sync_out, line_sync_out, serial_line_oe}, 12'h00E);
    rd(ADDR_AUX3, RST_AUX[2]);
    chk({4'h0, conv_aux[2]}, {4'h0, RST_AUX[2]});
  endtask
  // Two-lane 10-bit format set in standby; a zero word leaves clamped, MSB first.
  task automatic t_serial();
    logic [9:0] bits;
    int n;
    wr(ADDR_OUTFMT, {FMT_LVDS2, 4'h0});
    reflect();
    chk({11'h000, lvds4}, 12'h000);
    standby_release <= 1'b1;
    @(posedge clock);
    standby_release <= 1'b0;
    @(posedge clock);
    chk({11'h000, standby}, 12'h000);
    pixel_valid <= 1'b1;
    n = 0;
    @(posedge clock);
    while (pixel_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) begin
      num_errors++;
      return;
    end
    pixel_valid <= 1'b0;
    @(posedge clock);
    for (int b = 9; b >= 0; b--) begin
      @(negedge clock);
      bits[b] = serial_line_data;
      if (b == 9) chk(pixel_out, 12'h001);
    end
    chk({2'h0, bits}, 12'h001);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    repeat (500) @(posedge clock);
    t_defaults();
    t_hold();
    t_window();
    t_softreset();
    t_serial();
    close_out();
  end
endmodule
